// ---- hw/asa_alert_status.sv ----
`timescale 1ns/100ps
`default_nettype none
module asa_alert_status #(
    parameter int GRACE_CYCLES = asa_pkg::GRACE_CYCLES,
    parameter int TIMEOUT_CYCLES = asa_pkg::TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [15:0] modem_alert_flags,
    input wire logic [15:0] modem_alert_mask,
    input wire logic analog_open_detect,
    input wire logic analog_short_detect,
    input wire logic [1:0] out_enable,
    input wire logic [1:0] out_short,
    output logic [1:0] out_disable,
    input wire logic thermal_reset_event,
    input wire logic input_open_detect,
    input wire logic input_short_detect,
    input wire logic conv_error,
    input wire logic conv_saturation,
    input wire logic signed [9:0] die_temp_c,
    input wire logic power_tx_busy_error,
    input wire logic power_tx_ack_error,
    input wire logic serial_clock_count_error,
    input wire logic serial_crc_error,
    input wire logic supply_alert_any,
    input wire logic reset_event,
    output logic [15:0] alert_flags
);
    asa_flag_if fbus ();

    asa_flag_bank u_bank (
        .core_clk(core_clk),
        .reset(reset),
        .fb(fbus.bank)
    );

    logic modem_summary_alert;
    logic [1:0] timeout_event;
    logic [1:0] short_event;
    logic busy_prev;
    logic ack_prev;
    logic addr_hit;

    // Output stays forced off while its switch sits in the tripped state
    function automatic logic is_tripped(input asa_pkg::asa_switch_t sw);
        return sw == asa_pkg::ASA_SW_TRIPPED;
    endfunction : is_tripped

    // Stored flags with the two live summary bits laid over them
    function automatic logic [15:0] view_word(input logic [15:0] stored, input logic modem, input logic supply);
        logic [15:0] word;
        word = stored;
        word[asa_pkg::BIT_MODEM] = modem;
        word[asa_pkg::BIT_SUPPLY] = supply;
        return word;
    endfunction : view_word

    // Summary follows the modem flags live, so it clears by itself
    assign modem_summary_alert =
        |(modem_alert_flags & ~modem_alert_mask & ~asa_pkg::MODEM_EXCLUDE); // see [RULE_01] [RULE_02]

    assign addr_hit = (reg_addr == asa_pkg::ALERT_ADDR);

    // Output switch supervision: index 0 internal, 1 external
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_switch
            asa_pkg::asa_switch_t state;
            logic [asa_pkg::CNT_W-1:0] cnt;
            logic tripped;

            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    state <= asa_pkg::ASA_SW_OFF;
                    cnt <= '0;
                    tripped <= 1'b0;
                end
                else
                begin
                    tripped <= 1'b0;
                    case (state)
                        asa_pkg::ASA_SW_OFF:
                        begin
                            cnt <= '0;
                            if (out_enable[ch])
                                state <= asa_pkg::ASA_SW_GRACE;
                        end
                        asa_pkg::ASA_SW_GRACE:
                        begin
                            if (!out_enable[ch])
                                state <= asa_pkg::ASA_SW_OFF;
                            else if (cnt == asa_pkg::CNT_W'(GRACE_CYCLES - 1))
                            begin
                                state <= asa_pkg::ASA_SW_ON;
                                cnt <= '0;
                            end
                            else
                                cnt <= cnt + 1'b1;
                        end
                        asa_pkg::ASA_SW_ON:
                        begin
                            if (!out_enable[ch])
                                state <= asa_pkg::ASA_SW_OFF;
                            else if (!out_short[ch])
                                cnt <= '0;
                            else if (cnt == asa_pkg::CNT_W'(TIMEOUT_CYCLES - 1))
                            begin
                                state <= asa_pkg::ASA_SW_TRIPPED;
                                tripped <= 1'b1;
                            end
                            else
                                cnt <= cnt + 1'b1;
                        end
                        asa_pkg::ASA_SW_TRIPPED:
                        begin
                            // Stays off until the host drops the enable
                            if (!out_enable[ch])
                                state <= asa_pkg::ASA_SW_OFF;
                        end
                        default:
                            state <= asa_pkg::ASA_SW_OFF;
                    endcase
                end
            end

            // Shorts are not reported during the grace period
            assign short_event[ch] = (state == asa_pkg::ASA_SW_ON) && out_short[ch]; // see [RULE_07] [RULE_08]
            assign timeout_event[ch] = tripped; // see [RULE_05] [RULE_06]
        end
    endgenerate

    // Registered, so the disable follows the trip by one cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
            out_disable <= 2'h0;
        else
            out_disable <= {is_tripped(g_switch[1].state),
                            is_tripped(g_switch[0].state)};
    end

    // Error inputs are levels; only a fresh assertion marks a failed command
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busy_prev <= 1'b0;
            ack_prev <= 1'b0;
        end
        else
        begin
            busy_prev <= power_tx_busy_error;
            ack_prev <= power_tx_ack_error;
        end
    end

    always_comb
    begin
        fbus.set = 16'h0000;
        fbus.set[asa_pkg::BIT_AN_OPEN] = analog_open_detect; // see [RULE_03]
        fbus.set[asa_pkg::BIT_AN_SHORT] = analog_short_detect; // see [RULE_04]
        fbus.set[asa_pkg::BIT_INT_TIMEOUT] = timeout_event[0]; // see [RULE_05]
        fbus.set[asa_pkg::BIT_EXT_TIMEOUT] = timeout_event[1]; // see [RULE_06]
        fbus.set[asa_pkg::BIT_INT_SHORT] = short_event[0]; // see [RULE_07]
        fbus.set[asa_pkg::BIT_EXT_SHORT] = short_event[1]; // see [RULE_08]
        fbus.set[asa_pkg::BIT_THERM_RESET] = thermal_reset_event;
        fbus.set[asa_pkg::BIT_IN_OPEN] = input_open_detect; // see [RULE_09]
        fbus.set[asa_pkg::BIT_IN_SHORT] = input_short_detect; // see [RULE_10]
        fbus.set[asa_pkg::BIT_CONV] = conv_error | conv_saturation; // see [RULE_11]
        fbus.set[asa_pkg::BIT_TEMP] = (die_temp_c >= asa_pkg::TEMP_LIMIT_C); // see [RULE_12]
        fbus.set[asa_pkg::BIT_POWER] = (power_tx_busy_error & ~busy_prev)
                                     | (power_tx_ack_error & ~ack_prev); // see [RULE_13]
        fbus.set[asa_pkg::BIT_SERIAL] = serial_clock_count_error | serial_crc_error; // see [RULE_14]
        fbus.set[asa_pkg::BIT_RESET] = reset_event; // see [RULE_15]
    end

    // Only clear-on-one bits respond; zeros and summary bits are ignored
    assign fbus.clr = (reg_write && addr_hit) ? (reg_wdata & asa_pkg::W1C_MASK) : 16'h0000; // see [RULE_17]

    always_ff @(posedge core_clk)
    begin
        if (reset)
            alert_flags <= asa_pkg::ALERT_RESET;
        else
        begin
            // Live summary bits reach this copy on the same edge as the read path
            alert_flags <= view_word(fbus.flags, modem_summary_alert, supply_alert_any); // see [RULE_01]
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
            if (reg_read && addr_hit)
            begin
                // Summary bits are live, so a read sees their present state
                reg_rdata <= view_word(fbus.flags, modem_summary_alert, supply_alert_any); // see [RULE_02]
            end
            else if (reg_read)
                reg_rdata <= 16'h0000;
        end
    end
endmodule : asa_alert_status
`default_nettype wire

// ---- hw/asa_flag_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module asa_flag_bank (
    input wire logic core_clk,
    input wire logic reset,
    asa_flag_if.bank fb
);
    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
            fb.flags <= asa_pkg::ALERT_RESET; // see [RULE_15]
        else
            fb.flags <= ((fb.flags & ~fb.clr) | fb.set) & asa_pkg::W1C_MASK; // see [RULE_17]
    end
endmodule : asa_flag_bank
`default_nettype wire

// ---- hw/asa_flag_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface asa_flag_if;
    logic [15:0] set;
    logic [15:0] clr;
    logic [15:0] flags;
    modport bank (input set, input clr, output flags);
    modport ctrl (output set, output clr, input flags);
endinterface : asa_flag_if
`default_nettype wire

// ---- hw/asa_pkg.sv ----
// Contract
// [RULE_01] Bit 15 sets when any unmasked modem flag, except carrier and frame state, is set.
// [RULE_02] Bit 15 is read-only and clears once all such modem flags are zero or masked.
// [RULE_03] Bit 14 latches on analog open circuit and stays until written 1.
// [RULE_04] Bit 13 latches on analog short circuit and clears on write 1.
// [RULE_05] Internal output timeout flag latches when that output is tripped off.
// [RULE_06] External output timeout flag latches when that output is tripped off.
// [RULE_07] Internal output short flag latches on short, not during grace period.
// [RULE_08] External output short flag latches on short, not during grace period.
// [RULE_09] Digital input open-circuit flag latches on fault, clears on write 1.
// [RULE_10] Digital input short-circuit flag latches on fault, clears on write 1.
// [RULE_11] Converter flag latches on conversion error or saturation, clears on write 1.
// [RULE_12] Over-temperature flag latches at 115 C or above, clears on write 1.
// [RULE_13] Power-control flag latches when busy or acknowledge error asserts.
// [RULE_14] Serial flag latches on wrong clock count or CRC failure.
// [RULE_15] Reset flag is 1 after reset, sets on reset events, unmasked, write-1 clears.
// [RULE_16] Software clears a flag only after its fault has gone, else it sets again.
// [RULE_17] Writing 0 leaves flags unchanged; writes to summary bits are ignored.
package asa_pkg;
    localparam logic [6:0] ALERT_ADDR = 7'h41;
    localparam int FLAG_W = 16;
    localparam int BIT_MODEM = 15;
    localparam int BIT_AN_OPEN = 14;
    localparam int BIT_AN_SHORT = 13;
    localparam int BIT_INT_TIMEOUT = 12;
    localparam int BIT_EXT_TIMEOUT = 11;
    localparam int BIT_INT_SHORT = 10;
    localparam int BIT_EXT_SHORT = 9;
    localparam int BIT_THERM_RESET = 8;
    localparam int BIT_IN_OPEN = 7;
    localparam int BIT_IN_SHORT = 6;
    localparam int BIT_CONV = 5;
    localparam int BIT_TEMP = 4;
    localparam int BIT_POWER = 3;
    localparam int BIT_SERIAL = 2;
    localparam int BIT_SUPPLY = 1;
    localparam int BIT_RESET = 0;
    localparam logic [15:0] ALERT_RESET = 16'h0001;
    // Bits 15 and 1 are live summaries, never stored
    localparam logic [15:0] W1C_MASK = 16'h7FFD;
    localparam int MODEM_W = 16;
    localparam int CARRIER_BIT = 0;
    localparam int FRAME_MON_BIT = 1;
    localparam logic [15:0] MODEM_EXCLUDE = 16'h0003;
    localparam int TEMP_W = 10;
    localparam logic signed [9:0] TEMP_LIMIT_C = 10'h073;
    localparam int CLK_PERIOD_NS = 10;
    localparam int GRACE_TIME_NS = 100000;
    localparam int TIMEOUT_TIME_NS = 1000000;
    localparam int GRACE_CYCLES = GRACE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYCLES = TIMEOUT_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    typedef enum logic [1:0] {ASA_SW_OFF, ASA_SW_GRACE, ASA_SW_ON, ASA_SW_TRIPPED} asa_switch_t;
endpackage : asa_pkg

// ---- tb/asa_alert_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module asa_alert_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_read,
    input wire logic reg_rvalid,
    input wire logic [15:0] modem_alert_flags,
    input wire logic [15:0] modem_alert_mask,
    input wire logic analog_open_detect,
    input wire logic [1:0] out_enable,
    input wire logic [1:0] out_disable,
    input wire logic signed [9:0] die_temp_c,
    input wire logic serial_crc_error,
    input wire logic reset_event,
    input wire logic [15:0] alert_flags
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence both_off_s;
        (out_enable == 2'b00) [*3];
    endsequence
    rvalid_after_read_a: assert property (reg_read |=> reg_rvalid) else $error("rvalid missing");
    rvalid_idle_a: assert property (!reg_read |=> !reg_rvalid) else $error("rvalid without read");
    reset_value_a: assert property ($fell(reset) |-> alert_flags == 16'h0001) else $error("bad reset value");
    open_latch_a: assert property (analog_open_detect |-> ##2 alert_flags[14]) else $error("open lost");
    temp_latch_a: assert property (die_temp_c >= 10'sh073 |-> ##2 alert_flags[4]) else $error("temp lost");
    serial_latch_a: assert property (serial_crc_error |-> ##2 alert_flags[2]) else $error("serial lost");
    reset_latch_a: assert property (reset_event |-> ##2 alert_flags[0]) else $error("reset flag lost");
    modem_summary_a: assert property (!$past(reset) |-> alert_flags[15] ==
        $past(|(modem_alert_flags & ~modem_alert_mask & ~16'h0003))) else $error("modem summary wrong");
    output_release_a: assert property (both_off_s |-> out_disable == 2'b00) else $error("still off");
endmodule : asa_alert_checker
`default_nettype wire

// ---- tb/asa_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module asa_host_model (
    input wire logic core_clk,
    output logic reg_write,
    output logic reg_read,
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
    end
    // Callers clear a flag once its fault input is gone, except the set-wins test, which clears during the fault pulse, and the summary write tests
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        d = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask : rd
endmodule : asa_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [6:0] ADDR = asa_pkg::ALERT_ADDR;
    localparam int EVB [12] = '{14, 13, 8, 7, 6, 5, 5, 3, 3, 2, 2, 0};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_write, reg_read, reg_rvalid;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, alert_flags;
    logic [15:0] mflags = 16'h0000;
    logic [15:0] mmask = 16'h0000;
    logic [1:0] out_en = 2'b00;
    logic [1:0] out_sc = 2'b00;
    logic [1:0] out_dis;
    logic [11:0] ev = 12'h000;
    logic signed [9:0] temp = 10'h019;
    logic supply = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    always #5 core_clk = ~core_clk;
    asa_alert_status #(.GRACE_CYCLES(4), .TIMEOUT_CYCLES(8)) dut_u (.core_clk(core_clk), .reset(reset),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .modem_alert_flags(mflags), .modem_alert_mask(mmask),
        .analog_open_detect(ev[0]), .analog_short_detect(ev[1]), .out_enable(out_en), .out_short(out_sc),
        .out_disable(out_dis), .thermal_reset_event(ev[2]), .input_open_detect(ev[3]),
        .input_short_detect(ev[4]), .conv_error(ev[5]), .conv_saturation(ev[6]), .die_temp_c(temp),
        .power_tx_busy_error(ev[7]), .power_tx_ack_error(ev[8]), .serial_clock_count_error(ev[9]),
        .serial_crc_error(ev[10]), .supply_alert_any(supply), .reset_event(ev[11]), .alert_flags(alert_flags));
    asa_host_model host_u (.core_clk(core_clk), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rc(input logic [15:0] e, input string n);
        logic [15:0] d;
        host_u.rd(ADDR, d);
        chk(n, e, d);
    endtask : rc
    task automatic results;
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        chk("reset value", 16'h0001, alert_flags);
        host_u.wr(7'h40, 16'hFFFF);
        host_u.wr(ADDR, 16'h0000);
        rc(16'h0001, "write zero");
        host_u.wr(ADDR, 16'h0001);
        rc(16'h0000, "reset flag clear");
        for (int i = 0; i < 12; i++)
        begin
            ev[i] = 1'b1;
            @(negedge core_clk);
            ev[i] = 1'b0;
            repeat (2) @(negedge core_clk);
            rc(16'h0001 << EVB[i], "event set");
            host_u.wr(ADDR, 16'h0001 << EVB[i]);
            rc(16'h0000, "event clear");
        end
        temp = 10'h072;
        repeat (3) @(negedge core_clk);
        rc(16'h0000, "below limit");
        temp = 10'h073;
        repeat (3) @(negedge core_clk);
        temp = 10'h019;
        rc(16'h0010, "at limit");
        host_u.wr(ADDR, 16'h0010);
        mflags = 16'h0003;
        rc(16'h0000, "excluded modem");
        mflags = 16'h0024;
        mmask = 16'h0020;
        rc(16'h8000, "modem summary");
        host_u.wr(ADDR, 16'h8000);
        rc(16'h8000, "summary write");
        mmask = 16'h0024;
        rc(16'h0000, "modem masked");
        mflags = 16'h0000;
        out_en = 2'b11;
        repeat (2) @(negedge core_clk);
        out_sc = 2'b11;
        @(negedge core_clk);
        out_sc = 2'b00;
        rc(16'h0000, "grace short");
        repeat (4) @(negedge core_clk);
        out_sc = 2'b11;
        repeat (14) @(negedge core_clk);
        chk("tripped", 16'h0003, {14'h0000, out_dis});
        out_sc = 2'b00;
        out_en = 2'b00;
        repeat (3) @(negedge core_clk);
        chk("released", 16'h0000, {14'h0000, out_dis});
        rc(16'h1E00, "switch flags");
        host_u.wr(ADDR, 16'hFFFF);
        rc(16'h0000, "all clear");
        // Fault pulse and clear share one edge: the set must win
        fork
            host_u.wr(ADDR, 16'h4000);
            begin
                @(negedge core_clk);
                ev[0] = 1'b1;
                @(negedge core_clk);
                ev[0] = 1'b0;
            end
        join
        rc(16'h4000, "set wins");
        host_u.wr(ADDR, 16'h4000);
        supply = 1'b1;
        host_u.wr(ADDR, 16'h0002);
        rc(16'h0002, "supply write");
        reset = 1'b1;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        chk("mid reset value", 16'h0001, alert_flags);
        supply = 1'b0;
        rc(16'h0001, "mid reset read");
        results();
    end
    initial
    begin
        #100000;
        err_total++;
        results();
    end
endmodule : tb_top
bind asa_alert_status asa_alert_checker chk_u (.core_clk(core_clk), .reset(reset), .reg_read(reg_read),
    .reg_rvalid(reg_rvalid), .modem_alert_flags(modem_alert_flags), .modem_alert_mask(modem_alert_mask),
    .analog_open_detect(analog_open_detect), .out_enable(out_enable), .out_disable(out_disable),
    .die_temp_c(die_temp_c), .serial_crc_error(serial_crc_error), .reset_event(reset_event),
    .alert_flags(alert_flags));
`default_nettype wire
